// *** src/rpf_defs.svh ***
// register offsets, reset values and fixed constants of the receive packet filter
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH
`define RPF_OFS_LIMIT 8'h06
`define RPF_OFS_CTRL 8'h07
`define RPF_OFS_FRAME 8'h08
`define RPF_OFS_STATION 8'h09
`define RPF_OFS_STATUS 8'h0A
`define RPF_RST_LIMIT 8'hFF
`define RPF_RST_CTRL 8'h04
`define RPF_RST_FRAME 2'h1
`define RPF_RST_STATION 8'h00
`define RPF_PQ_MAX 5'h1F
`define RPF_PQ_INC 5'h01
`define RPF_PQ_DEC 5'h04
`define RPF_LEN_FIXED 2'h0
`define RPF_LEN_VAR 2'h1
`define RPF_FLT_OFF 2'h0
`define RPF_FLT_STATION 2'h1
`define RPF_FLT_ZERO 2'h2
`define RPF_FLT_BOTH 2'h3
`define RPF_BCAST_ZERO 8'h00
`define RPF_BCAST_ONES 8'hFF
`define RPF_BIT_LAST 3'h7
`define RPF_BUF_DEPTH 2'h2
`endif

// *** src/rpf_pkg.sv ***
// types shared by the receive packet filter
`default_nettype none
package rpf_pkg;
    typedef struct packed {
        logic [2:0] preamble_quality_threshold;
        logic spare;
        logic bad_check_discard_enable;
        logic trailer_append_enable;
        logic [1:0] dest_filter_mode;
    } rpf_ctrl_type;

    typedef enum logic [2:0] {
        RPF_HUNT = 3'h0,
        RPF_LEN = 3'h1,
        RPF_ADDR = 3'h3,
        RPF_DATA = 3'h2,
        RPF_CHECK = 3'h6,
        RPF_STAT1 = 3'h7,
        RPF_STAT2 = 3'h5
    } rpf_state_type;
endpackage : rpf_pkg
`default_nettype wire

// *** src/rpf_pq_estimator.sv ***
// preamble quality estimator: saturating transition counter
`timescale 1ns/1ps
`default_nettype none
`include "rpf_defs.svh"
module rpf_pq_estimator
    import rpf_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic restart,
    input wire logic bit_strobe,
    input wire logic bit_value,
    output logic [4:0] count
);
    logic [4:0] cnt_q, cnt_d;
    logic prev_q, prev_d, have_q, have_d;

    always_comb
    begin
        cnt_d = cnt_q;
        prev_d = prev_q;
        have_d = have_q;
        if (restart)
        begin
            cnt_d = 5'h00; // RL17
            have_d = 1'b0;
        end
        else if (bit_strobe)
        begin
            prev_d = bit_value;
            have_d = 1'b1;
            if (have_q && bit_value != prev_q)
            begin
                if (cnt_q != `RPF_PQ_MAX)
                    cnt_d = cnt_q + `RPF_PQ_INC; // RL3 RL5
            end
            else if (have_q)
            begin
                cnt_d = (cnt_q < `RPF_PQ_DEC) ? 5'h00 : cnt_q - `RPF_PQ_DEC; // RL4 RL5
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cnt_q <= 5'h00;
            prev_q <= 1'b0;
            have_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            prev_q <= prev_d;
            have_q <= have_d;
        end
    end

    assign count = cnt_q;

    AST_PQ_UP: assert property (@(posedge clock) disable iff (srst) // RL3
        !restart && bit_strobe && have_q && bit_value != prev_q && cnt_q < `RPF_PQ_MAX
        |=> cnt_q == $past(cnt_q) + `RPF_PQ_INC)
        else $error("pq counter did not step up on a transition");
    AST_PQ_DOWN: assert property (@(posedge clock) disable iff (srst) // RL4
        !restart && bit_strobe && have_q && bit_value == prev_q && cnt_q >= `RPF_PQ_DEC
        |=> cnt_q == $past(cnt_q) - `RPF_PQ_DEC)
        else $error("pq counter did not step down by four");
    AST_PQ_FLOOR: assert property (@(posedge clock) disable iff (srst) // RL5
        !restart && bit_strobe && have_q && bit_value == prev_q && cnt_q < `RPF_PQ_DEC
        |=> cnt_q == 5'h00)
        else $error("pq counter did not saturate at zero");
    AST_PQ_CEIL: assert property (@(posedge clock) disable iff (srst) // RL5
        !restart && cnt_q == `RPF_PQ_MAX && !(bit_strobe && have_q && bit_value == prev_q)
        |=> cnt_q == `RPF_PQ_MAX)
        else $error("pq counter left its ceiling without a repeat bit");
    AST_PQ_RESTART: assert property (@(posedge clock) disable iff (srst) // RL17
        restart |=> cnt_q == 5'h00 ##1 (cnt_q <= 5'h01))
        else $error("pq counter not cleared on restart");
endmodule : rpf_pq_estimator
`default_nettype wire

// *** src/rpf_pair_buffer.sv ***
// two-entry valid/ready buffer in front of the receive FIFO
`timescale 1ns/1ps
`default_nettype none
`include "rpf_defs.svh"
module rpf_pair_buffer
    import rpf_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    logic [WIDTH-1:0] e0_q, e0_d, e1_q, e1_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;
    logic valid_q, valid_d;

    always_comb
    begin
        push = in_valid && (cnt_q != `RPF_BUF_DEPTH);
        pop = (cnt_q != 2'h0) && out_ready;
        e0_d = e0_q;
        e1_d = e1_q;
        cnt_d = cnt_q;
        if (flush)
            cnt_d = 2'h0;
        else if (push && pop)
        begin
            e0_d = (cnt_q == 2'h1) ? in_data : e1_q;
            e1_d = in_data;
        end
        else if (pop)
        begin
            e0_d = e1_q;
            cnt_d = cnt_q - 2'h1;
        end
        else if (push)
        begin
            if (cnt_q == 2'h0)
                e0_d = in_data;
            else
                e1_d = in_data;
            cnt_d = cnt_q + 2'h1;
        end
        // fifo side sees a flop, not a compare on the count
        valid_d = (cnt_d != 2'h0);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            e0_q <= '0;
            e1_q <= '0;
            cnt_q <= 2'h0;
            valid_q <= 1'h0;
        end
        else
        begin
            e0_q <= e0_d;
            e1_q <= e1_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
        end
    end

    assign in_ready = (cnt_q != `RPF_BUF_DEPTH);
    assign out_valid = valid_q;
    assign out_data = e0_q;
endmodule : rpf_pair_buffer
`default_nettype wire

// *** src/rpf_top.sv ***
// receive packet filter: length limit, preamble gate, address filter, trailer, discard
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rpf_defs.svh"
// Operation
// [RL1] fixed framing: length register gives exact payload byte count
// [RL2] variable framing: length register caps accepted length byte
// [RL3] quality counter rises by one on each bit differing from previous
// [RL4] quality counter falls by four on each bit equal to previous
// [RL5] quality counter saturates at zero and thirty-one
// [RL6] sync accepted only while counter at least four times threshold
// [RL7] threshold zero accepts every sync word
// [RL8] discard bit and failed check flush the receive FIFO
// [RL9] host uses discard only with one short packet in FIFO
// [RL10] trailer bit appends two status bytes after payload
// [RL11] trailer holds signal strength, link quality and check-ok flag
// [RL12] filter mode 00 no filter, 01 station address only
// [RL13] mode 10 adds 0x00 broadcast, mode 11 adds 0x00 and 0xFF
// [RL14] length mode 00 fixed from register, 01 from first byte
// [RL15] programmable 8-bit station address compared to address byte
// [RL16] packets failing the address filter are dropped from the FIFO
// [RL17] quality counter restarts from zero when sync search begins
module rpf_top
    import rpf_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic bit_valid,
    input wire logic bit_value,
    output logic bit_ready,
    input wire logic sync_hit,
    input wire logic rx_restart,
    input wire logic check_done,
    input wire logic check_ok,
    input wire logic [7:0] signal_strength_value,
    input wire logic [6:0] link_quality_value,
    output logic fifo_valid,
    output logic [7:0] fifo_data,
    input wire logic fifo_ready,
    output logic fifo_flush
);
    // register file
    logic [7:0] limit_q, limit_d, station_q, station_d, rdata_q, rdata_d;
    rpf_ctrl_type ctrl_q, ctrl_d;
    logic [1:0] len_mode_q, len_mode_d;

    // framing state
    rpf_state_type state_q, state_d;
    logic [7:0] shift_q, shift_d, rem_q, rem_d, pend_byte_q, pend_byte_d;
    logic [2:0] bitcnt_q, bitcnt_d;
    logic pend_q, pend_d, ready_q, ready_d, flush_q, flush_d, ok_q, ok_d;

    logic bit_take, byte_done, pq_pass, pq_restart, addr_ok, buf_in_ready;
    logic [7:0] byte_val;
    logic [4:0] pq_count;

    assign bit_take = bit_valid && ready_q;
    assign byte_val = {shift_q[6:0], bit_value};
    assign byte_done = bit_take && (state_q != RPF_HUNT) && (bitcnt_q == `RPF_BIT_LAST);
    assign pq_pass = (ctrl_q.preamble_quality_threshold == 3'h0) // RL7
        || (pq_count >= {ctrl_q.preamble_quality_threshold, 2'h0}); // RL6
    // search begins whenever the framer falls back to hunting
    assign pq_restart = rx_restart || (state_q != RPF_HUNT && state_d == RPF_HUNT); // RL17

    always_comb
    begin
        unique case (ctrl_q.dest_filter_mode) // RL12 RL13
            `RPF_FLT_OFF: addr_ok = 1'b1;
            `RPF_FLT_STATION: addr_ok = (byte_val == station_q); // RL15
            `RPF_FLT_ZERO: addr_ok = (byte_val == station_q) || (byte_val == `RPF_BCAST_ZERO);
            `RPF_FLT_BOTH: addr_ok = (byte_val == station_q) || (byte_val == `RPF_BCAST_ZERO)
                || (byte_val == `RPF_BCAST_ONES);
        endcase
    end

    rpf_pq_estimator u_pq (
        .clock(clock),
        .srst(srst),
        .restart(pq_restart),
        .bit_strobe(bit_take && state_q == RPF_HUNT),
        .bit_value(bit_value),
        .count(pq_count)
    );

    rpf_pair_buffer #(.WIDTH(8)) u_buf (
        .clock(clock),
        .srst(srst),
        .flush(flush_q),
        .in_valid(pend_q),
        .in_data(pend_byte_q),
        .in_ready(buf_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_ready)
    );

    // register bus
    always_comb
    begin
        limit_d = limit_q;
        ctrl_d = ctrl_q;
        len_mode_d = len_mode_q;
        station_d = station_q;
        rdata_d = 8'h00;
        if (reg_we)
        begin
            unique case (reg_addr)
                `RPF_OFS_LIMIT: limit_d = reg_wdata;
                `RPF_OFS_CTRL: ctrl_d = rpf_ctrl_type'(reg_wdata);
                `RPF_OFS_FRAME: len_mode_d = reg_wdata[1:0];
                `RPF_OFS_STATION: station_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_re)
        begin
            unique case (reg_addr)
                `RPF_OFS_LIMIT: rdata_d = limit_q;
                `RPF_OFS_CTRL: rdata_d = ctrl_q;
                `RPF_OFS_FRAME: rdata_d = {6'h00, len_mode_q};
                `RPF_OFS_STATION: rdata_d = station_q;
                `RPF_OFS_STATUS: rdata_d = {pq_count, pq_pass, ok_q, state_q != RPF_HUNT};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            limit_q <= `RPF_RST_LIMIT;
            ctrl_q <= rpf_ctrl_type'(`RPF_RST_CTRL);
            len_mode_q <= `RPF_RST_FRAME;
            station_q <= `RPF_RST_STATION;
            rdata_q <= 8'h00;
        end
        else
        begin
            limit_q <= limit_d;
            ctrl_q <= ctrl_d;
            len_mode_q <= len_mode_d;
            station_q <= station_d;
            rdata_q <= rdata_d;
        end
    end

    // framer
    always_comb
    begin
        state_d = state_q;
        shift_d = shift_q;
        bitcnt_d = bitcnt_q;
        rem_d = rem_q;
        pend_d = pend_q;
        pend_byte_d = pend_byte_q;
        flush_d = 1'b0;
        ok_d = ok_q;
        if (pend_q && buf_in_ready)
            pend_d = 1'b0;
        if (bit_take)
        begin
            shift_d = byte_val;
            bitcnt_d = (state_q == RPF_HUNT) ? 3'h0 : bitcnt_q + 3'h1;
        end
        if (byte_done)
        begin
            pend_d = 1'b1;
            pend_byte_d = byte_val;
        end
        unique case (state_q)
            RPF_HUNT:
            begin
                if (sync_hit && pq_pass) // RL6 RL7
                begin
                    bitcnt_d = 3'h0;
                    rem_d = limit_q; // RL1
                    if (len_mode_q == `RPF_LEN_VAR) // RL14
                        state_d = RPF_LEN;
                    else if (limit_q == 8'h00)
                        state_d = RPF_CHECK;
                    else if (ctrl_q.dest_filter_mode != `RPF_FLT_OFF)
                        state_d = RPF_ADDR;
                    else
                        state_d = RPF_DATA;
                end
            end
            RPF_LEN:
            begin
                if (byte_done)
                begin
                    rem_d = byte_val; // RL14
                    if (byte_val > limit_q) // RL2
                    begin
                        pend_d = 1'b0;
                        flush_d = 1'b1;
                        state_d = RPF_HUNT;
                    end
                    else if (byte_val == 8'h00)
                        state_d = RPF_CHECK;
                    else if (ctrl_q.dest_filter_mode != `RPF_FLT_OFF)
                        state_d = RPF_ADDR;
                    else
                        state_d = RPF_DATA;
                end
            end
            RPF_ADDR:
            begin
                if (byte_done)
                begin
                    rem_d = rem_q - 8'h01;
                    if (!addr_ok) // RL16
                    begin
                        pend_d = 1'b0;
                        flush_d = 1'b1;
                        state_d = RPF_HUNT;
                    end
                    else
                        state_d = (rem_q == 8'h01) ? RPF_CHECK : RPF_DATA;
                end
            end
            RPF_DATA:
            begin
                if (byte_done)
                begin
                    rem_d = rem_q - 8'h01; // RL1
                    if (rem_q == 8'h01)
                        state_d = RPF_CHECK;
                end
            end
            RPF_CHECK:
            begin
                if (check_done)
                begin
                    ok_d = check_ok;
                    if (ctrl_q.bad_check_discard_enable && !check_ok) // RL8
                    begin
                        pend_d = 1'b0;
                        flush_d = 1'b1;
                        state_d = RPF_HUNT;
                    end
                    else if (ctrl_q.trailer_append_enable) // RL10
                        state_d = RPF_STAT1;
                    else
                        state_d = RPF_HUNT;
                end
            end
            RPF_STAT1:
            begin
                if (!pend_q)
                begin
                    pend_d = 1'b1;
                    pend_byte_d = signal_strength_value; // RL11
                    state_d = RPF_STAT2;
                end
            end
            RPF_STAT2:
            begin
                if (!pend_q)
                begin
                    pend_d = 1'b1;
                    pend_byte_d = {ok_q, link_quality_value}; // RL11
                    state_d = RPF_HUNT;
                end
            end
            default:
                state_d = RPF_HUNT;
        endcase
        if (rx_restart)
            state_d = RPF_HUNT;
        // a held byte stalls the bitstream so no bit is lost
        ready_d = !pend_d;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= RPF_HUNT;
            shift_q <= 8'h00;
            bitcnt_q <= 3'h0;
            rem_q <= 8'h00;
            pend_q <= 1'b0;
            pend_byte_q <= 8'h00;
            ready_q <= 1'b1;
            flush_q <= 1'b0;
            ok_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            shift_q <= shift_d;
            bitcnt_q <= bitcnt_d;
            rem_q <= rem_d;
            pend_q <= pend_d;
            pend_byte_q <= pend_byte_d;
            ready_q <= ready_d;
            flush_q <= flush_d;
            ok_q <= ok_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign bit_ready = ready_q;
    assign fifo_flush = flush_q;

    AST_SYNC_GATED: assert property (@(posedge clock) disable iff (srst) // RL6
        state_q == RPF_HUNT && sync_hit && !pq_pass |=> state_q == RPF_HUNT)
        else $error("sync accepted below the quality threshold");
    AST_SYNC_FREE: assert property (@(posedge clock) disable iff (srst) // RL7
        state_q == RPF_HUNT && sync_hit && !rx_restart
        && ctrl_q.preamble_quality_threshold == 3'h0 |=> state_q != RPF_HUNT)
        else $error("sync refused with zero threshold");
    AST_OVERSIZE: assert property (@(posedge clock) disable iff (srst) // RL2
        state_q == RPF_LEN && byte_done && byte_val > limit_q
        |=> fifo_flush && state_q == RPF_HUNT)
        else $error("oversize packet not dropped");
    AST_ADDR_DROP: assert property (@(posedge clock) disable iff (srst) // RL16
        state_q == RPF_ADDR && byte_done && !addr_ok |=> fifo_flush ##1 !fifo_flush)
        else $error("address mismatch not flushed");
    AST_BAD_CHECK: assert property (@(posedge clock) disable iff (srst) // RL8
        state_q == RPF_CHECK && check_done && !check_ok
        && ctrl_q.bad_check_discard_enable |=> fifo_flush)
        else $error("failed check not flushed");
    AST_TRAILER: assert property (@(posedge clock) disable iff (srst) // RL10
        state_q == RPF_CHECK && check_done && !rx_restart && ctrl_q.trailer_append_enable
        && (check_ok || !ctrl_q.bad_check_discard_enable) |=> state_q == RPF_STAT1)
        else $error("trailer not started after payload");
    AST_TRAILER_OK: assert property (@(posedge clock) disable iff (srst) // RL11
        state_q == RPF_STAT2 && !pend_q |=> pend_q && pend_byte_q[7] == ok_q)
        else $error("trailer check flag wrong");
    AST_FIXED_LEN: assert property (@(posedge clock) disable iff (srst) // RL1
        state_q == RPF_HUNT && sync_hit && pq_pass && !rx_restart
        && len_mode_q == `RPF_LEN_FIXED |=> rem_q == $past(limit_q))
        else $error("fixed length not loaded from limit");
endmodule : rpf_top
`default_nettype wire

// *** testbench/rpf_fifo_model.sv ***
// receive fifo stand-in: collects bytes, empties on flush
`timescale 1ns/1ps
`default_nettype none
module rpf_fifo_model
(
    input wire logic clock,
    input wire logic srst,
    input wire logic stall,
    input wire logic fifo_valid,
    input wire logic [7:0] fifo_data,
    input wire logic fifo_flush,
    output logic fifo_ready
);
    logic [7:0] got[$];
    assign fifo_ready = !stall;
    always @(posedge clock)
    begin
        // a byte taken with the flush belongs to the dropped packet
        if (srst || fifo_flush)
        begin
            got.delete();
        end
        else if (fifo_valid && fifo_ready)
        begin
            got.push_back(fifo_data);
        end
    end
endmodule : rpf_fifo_model
`default_nettype wire

// *** testbench/rpf_top_bench.sv ***
// self-checking bench for the receive packet filter
`timescale 1ns/1ps
`default_nettype none
`include "rpf_defs.svh"
module rpf_top_bench
    import rpf_pkg::*;
;
    logic clock, srst, reg_we, reg_re, bit_valid, bit_value, sync_hit, rx_restart;
    logic check_done, check_ok, fifo_ready, fifo_valid, fifo_flush, bit_ready, stall, stall_all;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_data, sig_str, d, lim, sta, w;
    logic [6:0] lq;
    logic [4:0] c;
    logic [1:0] fm, sel;
    logic ok;
    rpf_ctrl_type ctrl;
    int err_count, checked, seed, n;
    logic [7:0] pay[$];
    logic [7:0] exp_q[$];
    logic [63:0] pat[4];
    logic [7:0] r_addr[6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0B, 8'hFE};
    logic [7:0] r_rst[6] = '{8'hFF, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00};

    rpf_top dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .bit_valid,
        .bit_value, .bit_ready, .sync_hit, .rx_restart, .check_done, .check_ok,
        .signal_strength_value(sig_str), .link_quality_value(lq), .fifo_valid, .fifo_data,
        .fifo_ready, .fifo_flush);
    rpf_fifo_model m (.clock, .srst, .stall, .fifo_valid, .fifo_data, .fifo_flush, .fifo_ready);

    initial
    begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
    begin
        stall <= stall_all | (($random(seed) & 3) == 0);
    end

    task stop_test();
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task chk_fifo();
        chk(8'(m.got.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) chk(m.got[i], exp_q[i]);
    endtask : chk_fifo

    task wr(input logic [7:0] a, input logic [7:0] v);
        reg_we <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_we <= 1'h0;
        // idle edge so back-to-back writes never re-drive the strobe in one step
        @(posedge clock);
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        reg_re <= 1'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_re <= 1'h0;
        @(posedge clock);
        v = reg_rdata;
    endtask : rd

    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            bit_valid <= 1'h1;
            bit_value <= b[i];
            do @(posedge clock); while (bit_ready !== 1'h1);
        end
    endtask : send_byte

    function automatic logic [4:0] pq_next(input logic [4:0] q, input logic same);
        if (same)
            return (q < 5'h4) ? 5'h0 : q - 5'h4;
        return (q == 5'h1F) ? q : q + 5'h1;
    endfunction : pq_next

    // restart the hunt, then feed n bits lsb of the pattern first
    task feed(input logic [63:0] bits, input int cnt);
        rx_restart <= 1'h1;
        @(posedge clock);
        rx_restart <= 1'h0;
        c = 5'h0;
        for (int i = 0; i < cnt; i++)
        begin
            bit_valid <= 1'h1;
            bit_value <= bits[i];
            @(posedge clock);
            if (i > 0)
                c = pq_next(c, bits[i] == bits[i - 1]);
        end
        bit_valid <= 1'h0;
    endtask : feed

    function automatic void exp_pkt(rpf_ctrl_type k, logic [1:0] f, logic [7:0] l,
        logic [7:0] s, logic pass);
        logic hit;
        exp_q = pay;
        hit = (pay.size() == 0) || (pay[0] == s) || (k.dest_filter_mode[1] && pay[0] == 8'h00)
            || (k.dest_filter_mode == 2'h3 && pay[0] == 8'hFF);
        if (f == `RPF_LEN_VAR)
            exp_q.push_front(8'(pay.size()));
        if ((f == `RPF_LEN_VAR && pay.size() > l) || (k.dest_filter_mode != 2'h0 && !hit)
            || (!pass && k.bad_check_discard_enable))
            exp_q.delete();
        else if (k.trailer_append_enable)
        begin
            exp_q.push_back(sig_str);
            exp_q.push_back({pass, lq});
        end
    endfunction : exp_pkt

    initial
    begin
        repeat (30000) @(posedge clock);
        err_count++;
        stop_test();
    end

    initial
    begin
        seed = 32'hD9B2;
        err_count = 0;
        checked = 0;
        {srst, reg_we, reg_re, bit_valid, bit_value, sync_hit} = 6'h20;
        {rx_restart, check_done, check_ok, stall, stall_all} = 5'h0;
        {reg_addr, reg_wdata, sig_str, lq} = 31'h0;
        repeat (4) @(posedge clock);
        srst <= 1'h0;
        foreach (r_addr[i])
        begin
            rd(r_addr[i], d);
            chk(d, r_rst[i]);
        end
        foreach (r_addr[i])
        begin
            w = 8'($random(seed));
            if (i != 2)
            begin
                wr(r_addr[i], w);
                rd(r_addr[i], d);
                chk(d, (i < 4) ? w : 8'h00);
            end
        end
        wr(`RPF_OFS_CTRL, 8'h00);
        pat = '{{$random(seed), $random(seed)}, 64'hAAAA_AAAA_AAAA_AAAA,
            64'hFFFF_FFFF_5555_5555, {$random(seed), $random(seed)}};
        foreach (pat[i])
        begin
            feed(pat[i], 64);
            rd(`RPF_OFS_STATUS, d);
            chk(d[7:3], c);
        end
        // counts of 4t-1 and 4t sit right on the gate
        for (int t = 0; t < 8; t++)
        begin
            for (int e = 0; e < 2; e++)
            begin
                wr(`RPF_OFS_CTRL, {3'(t), 5'h0});
                feed(64'hAAAA_AAAA_AAAA_AAAA, 4 * t + e);
                sync_hit <= 1'h1;
                @(posedge clock);
                sync_hit <= 1'h0;
                rd(`RPF_OFS_STATUS, d);
                chk(d[0], (t == 0) || (c >= 4 * t));
            end
        end
        for (int k = 0; k < 30; k++)
        begin
            ctrl = rpf_ctrl_type'(8'($random(seed)));
            ctrl.preamble_quality_threshold = 3'h0;
            fm = 2'($random(seed));
            lim = 8'($random(seed) & 7);
            sta = 8'($random(seed));
            sel = 2'($random(seed));
            ok = 1'($random(seed));
            sig_str <= 8'($random(seed));
            lq <= 7'($random(seed));
            // a long frame against a stalled fifo fills the buffer
            stall_all <= (k == 5);
            if (k == 5)
            begin
                fm = `RPF_LEN_FIXED;
                lim = 8'h07;
            end
            wr(`RPF_OFS_CTRL, ctrl);
            wr(`RPF_OFS_FRAME, {6'h0, fm});
            wr(`RPF_OFS_LIMIT, lim);
            wr(`RPF_OFS_STATION, sta);
            n = (fm == `RPF_LEN_VAR) ? ($random(seed) & 7) : lim;
            pay.delete();
            for (int i = 0; i < n; i++) pay.push_back(8'($random(seed)));
            if (n > 0)
                pay[0] = (sel == 0) ? sta : (sel == 1) ? 8'h00 : (sel == 2) ? 8'hFF : pay[0];
            exp_pkt(ctrl, fm, lim, sta, ok);
            rx_restart <= 1'h1;
            @(posedge clock);
            rx_restart <= 1'h0;
            sync_hit <= 1'h1;
            @(posedge clock);
            sync_hit <= 1'h0;
            fork
                begin
                    if (fm == `RPF_LEN_VAR)
                        send_byte(8'(n));
                    foreach (pay[i]) send_byte(pay[i]);
                    bit_valid <= 1'h0;
                end
                begin
                    repeat (40) @(posedge clock);
                    stall_all <= 1'h0;
                end
            join
            repeat (3) @(posedge clock);
            while (bit_ready !== 1'h1) @(posedge clock);
            repeat (2) @(posedge clock);
            check_done <= 1'h1;
            check_ok <= ok;
            @(posedge clock);
            check_done <= 1'h0;
            repeat (30) @(posedge clock);
            chk_fifo();
            m.got.delete();
        end
        stop_test();
    end
endmodule : rpf_top_bench
`default_nettype wire
